// ==== common/nv_pkg.sv ====
// constants and types of the nonvolatile memory access controller
// assumes a single 100 MHz core clock and an 8-bit register port
package nv_pkg;
    localparam logic [8:0] ADDR_CTRL = 9'h18c;
    localparam logic [8:0] ADDR_UNLOCK = 9'h18d;
    localparam logic [8:0] ADDR_DATA_LO = 9'h10c;
    localparam logic [8:0] ADDR_ADDR_LO = 9'h10d;
    localparam logic [8:0] ADDR_DATA_HI = 9'h10e;
    localparam logic [8:0] ADDR_ADDR_HI = 9'h10f;
    localparam logic [8:0] ADDR_FLAGS2 = 9'h00d;
    localparam int FLAG_DONE_BIT = 4;
    localparam int WR_BIT = 1;
    localparam int RD_BIT = 0;
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;
    localparam int EE_DEPTH = 256;
    localparam int EE_AW = 8;
    localparam int FLASH_AW = 12;
    localparam int FLASH_DW = 14;
    localparam int ROW_WORDS = 32;
    localparam int BLOCK_WORDS = 4;
    localparam logic [13:0] ERASED_WORD = 14'h3fff;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CLK_PERIOD_NS = 10;
    localparam int WRITE_TIME_NS = 2000000;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic space;
        logic [1:0] unused;
        logic free;
        logic abort;
        logic permit;
        logic wr;
        logic rd;
    } ctrl_t;

    typedef enum logic [1:0] {U_IDLE, U_HALF, U_ARMED} unlock_st_t;
    typedef enum logic [1:0] {S_IDLE, S_ARRAY, S_TIMER} op_st_t;
endpackage

// ==== src/nv_mem.sv ====
// simple dual-port array with registered read data
// assumes no reset of contents; read and write ports are independent
`timescale 1ns/1ps
module nv_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic i_re,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// ==== src/nv_unlock.sv ====
// tracks the two-step unlock sequence on the unlock port
// assumes one register write per cycle from the core
`timescale 1ns/1ps
module nv_unlock (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_clear,
    input wire logic i_wr,
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_armed
);
    nv_pkg::unlock_st_t st;
    logic first_ok;
    logic second_ok;

    assign first_ok = i_addr == nv_pkg::ADDR_UNLOCK && i_wdata == nv_pkg::UNLOCK_FIRST;
    assign second_ok = i_addr == nv_pkg::ADDR_UNLOCK && i_wdata == nv_pkg::UNLOCK_SECOND;
    assign o_armed = st == nv_pkg::U_ARMED;

    // exact order only
    // any other write but a repeated 55h, the start write included, drops the sequence
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= nv_pkg::U_IDLE;
        end else if (i_clear) begin
            st <= nv_pkg::U_IDLE;
        end else if (i_wr) begin
            case (st)
                nv_pkg::U_HALF: begin
                    st <= second_ok ? nv_pkg::U_ARMED : (first_ok ? nv_pkg::U_HALF : nv_pkg::U_IDLE);
                end
                default: begin
                    st <= first_ok ? nv_pkg::U_HALF : nv_pkg::U_IDLE;
                end
            endcase
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    AST_ARM_ORDER: assert property ($rose(o_armed) |-> $past(i_wr && second_ok) &&
        $past(st == nv_pkg::U_HALF)) else $error("armed without 55h then AAh");
endmodule

// ==== src/nv_access_ctrl.sv ====
// access controller for data EEPROM and program flash behind 8-bit registers
// assumes the core drives one-cycle read/write strobes; read data next cycle
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// - space bit: 0 EEPROM, 1 flash; reset clears
// - start bits set by software, cleared by hardware
// - writes need write permit; clear at power-up
// - reset during write flags abort, keeps address/data
// - write completion sets done flag; software clears
// - unlock port stores nothing, reads zero
// - EEPROM uses low data byte, 256 bytes
// - unimplemented EEPROM address keeps pump off
// - flash uses 14-bit data, 13-bit address
// - flash 4K words, higher addresses wrap
// - EEPROM byte write erases then programs
// - flash word reads; 32-word erase, 4-word program
// - internal timer sets write length; pump internal
// - code protect: only drives external program block; flash writes gated by write protect
// - data address low only; flash uses pair
// - unimplemented address bits ignored
// - unlock 55h then AAh then start
// - start refused without permit; later clear harmless
// - EEPROM read data in data register two cycles after start
module nv_access_ctrl #(
    parameter int EE_DEPTH = nv_pkg::EE_DEPTH,
    parameter int WRITE_CYCLES = nv_pkg::WRITE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [8:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_ext_reset_pin_n,
    input wire logic i_wdt_timeout,
    input wire logic i_flash_wp,
    input wire logic i_code_protect,
    output logic [7:0] o_rdata,
    output logic o_charge_pump,
    output logic o_write_done_flag,
    output logic o_write_abort_flag,
    output logic o_ext_prog_block
);
    if (EE_DEPTH < 1 || EE_DEPTH > (1 << nv_pkg::EE_AW) || WRITE_CYCLES < 1) begin : g_chk
        $error("nv_access_ctrl: unsupported parameters");
    end

    nv_pkg::ctrl_t ctrl;
    nv_pkg::op_st_t st;
    logic [7:0] data_lo;
    logic [5:0] data_hi;
    logic [7:0] addr_lo;
    logic [4:0] addr_hi;
    logic done_flag;
    logic pin_s1, pin_s2, pin_s3, ext_held;
    logic core_rst, armed, start_wr, start_rd;
    logic wr_ctrl, ee_unimpl;
    logic [4:0] cnt, last;
    logic [31:0] tmr;
    logic op_ee, op_erase;
    logic [11:0] op_addr;
    logic [13:0] op_data;
    logic [13:0] blk [0:2];
    logic [7:0] ee_rdata;
    logic [13:0] fl_rdata;
    logic [11:0] fl_waddr;
    logic [13:0] fl_wdata;

    function automatic logic [11:0] flash_word(input logic [4:0] h, input logic [7:0] l);
        logic [12:0] full;
        full = {h, l};
        return full[11:0];
    endfunction

    // external reset pin: three flops, change taken once stages two and three agree
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            pin_s3 <= 1'b1;
            ext_held <= 1'b0;
        end else begin
            pin_s1 <= i_ext_reset_pin_n;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                ext_held <= !pin_s3;
            end
        end
    end

    assign core_rst = ext_held || i_wdt_timeout;
    assign wr_ctrl = i_wr && i_addr == nv_pkg::ADDR_CTRL;
    assign ee_unimpl = 32'(addr_lo) >= EE_DEPTH;
    assign start_wr = wr_ctrl && i_wdata[nv_pkg::WR_BIT] && ctrl.permit && armed && !ctrl.wr && !core_rst;
    assign start_rd = wr_ctrl && i_wdata[nv_pkg::RD_BIT] && !ctrl.wr && !ctrl.rd && !core_rst && !start_wr;

    nv_unlock u_unlock (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_clear(core_rst),
        .i_wr(i_wr),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .o_armed(armed)
    );

    nv_mem #(.AW(nv_pkg::EE_AW), .DW(8)) u_ee (
        .i_clk(i_clk),
        .i_we(st == nv_pkg::S_ARRAY && op_ee),
        .i_waddr(op_addr[7:0]),
        .i_wdata(op_data[7:0]),
        .i_re(start_rd),
        .i_raddr(addr_lo),
        .o_rdata(ee_rdata)
    );

    assign fl_waddr = op_addr | 12'(cnt);
    assign fl_wdata = op_erase ? nv_pkg::ERASED_WORD : (cnt == 5'h3 ? op_data : blk[cnt[1:0]]);

    nv_mem #(.AW(nv_pkg::FLASH_AW), .DW(nv_pkg::FLASH_DW)) u_flash (
        .i_clk(i_clk),
        .i_we(st == nv_pkg::S_ARRAY && !op_ee),
        .i_waddr(fl_waddr),
        .i_wdata(fl_wdata),
        .i_re(start_rd),
        .i_raddr(flash_word(addr_hi, addr_lo)),
        .o_rdata(fl_rdata)
    );

    // data and address registers: core reset leaves them alone so software can retry
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            data_lo <= 8'h00;
            data_hi <= 6'h00;
            addr_lo <= 8'h00;
            addr_hi <= 5'h00;
        end else if (ctrl.rd) begin
            data_lo <= ctrl.space ? fl_rdata[7:0] : ee_rdata;
            if (ctrl.space) begin
                data_hi <= fl_rdata[13:8];
            end
        end else if (i_wr) begin
            case (i_addr)
                nv_pkg::ADDR_DATA_LO: data_lo <= i_wdata;
                nv_pkg::ADDR_DATA_HI: data_hi <= i_wdata[5:0];
                nv_pkg::ADDR_ADDR_LO: addr_lo <= i_wdata;
                nv_pkg::ADDR_ADDR_HI: addr_hi <= i_wdata[4:0];
                default: data_lo <= data_lo;
            endcase
        end
    end

    // control register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl <= nv_pkg::CTRL_RESET;
        end else if (core_rst) begin
            ctrl <= nv_pkg::CTRL_RESET;
            ctrl.abort <= ctrl.abort || ctrl.wr;
        end else begin
            if (wr_ctrl) begin
                ctrl.space <= i_wdata[7];
                ctrl.free <= i_wdata[4];
                ctrl.abort <= i_wdata[3];
                ctrl.permit <= i_wdata[2];
            end
            if (start_rd) begin
                ctrl.rd <= 1'b1;
            end else if (ctrl.rd) begin
                ctrl.rd <= 1'b0;
            end
            if (start_wr) begin
                ctrl.wr <= 1'b1;
            end else if (st == nv_pkg::S_TIMER && tmr == 32'd0) begin
                ctrl.wr <= 1'b0;
            end
        end
    end

    // write engine
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= nv_pkg::S_IDLE;
            cnt <= 5'h00;
            last <= 5'h00;
            tmr <= 32'd0;
            op_ee <= 1'b0;
            op_erase <= 1'b0;
            op_addr <= 12'h000;
            op_data <= 14'h0000;
            o_charge_pump <= 1'b0;
        end else if (core_rst) begin
            st <= nv_pkg::S_IDLE;
            o_charge_pump <= 1'b0;
        end else begin
            case (st)
                nv_pkg::S_IDLE: begin
                    cnt <= 5'h00;
                    tmr <= 32'd0;
                    if (start_wr) begin
                        op_ee <= !ctrl.space;
                        op_erase <= ctrl.free;
                        op_data <= {data_hi, data_lo};
                        st <= nv_pkg::S_TIMER;
                        if (!ctrl.space) begin
                            op_addr <= {4'h0, addr_lo};
                            if (!ee_unimpl) begin
                                st <= nv_pkg::S_ARRAY;
                                last <= 5'h00;
                                o_charge_pump <= 1'b1;
                            end
                        end else if (!i_flash_wp) begin
                            if (ctrl.free) begin
                                op_addr <= flash_word(addr_hi, addr_lo) & ~12'(nv_pkg::ROW_WORDS - 1);
                                last <= 5'(nv_pkg::ROW_WORDS - 1);
                                st <= nv_pkg::S_ARRAY;
                                o_charge_pump <= 1'b1;
                            end else if (addr_lo[1:0] == 2'(nv_pkg::BLOCK_WORDS - 1)) begin
                                op_addr <= flash_word(addr_hi, addr_lo) & ~12'(nv_pkg::BLOCK_WORDS - 1);
                                last <= 5'(nv_pkg::BLOCK_WORDS - 1);
                                st <= nv_pkg::S_ARRAY;
                                o_charge_pump <= 1'b1;
                            end
                        end
                    end
                end
                nv_pkg::S_ARRAY: begin
                    cnt <= cnt + 5'h01;
                    if (cnt == last) begin
                        st <= nv_pkg::S_TIMER;
                        tmr <= 32'(WRITE_CYCLES - 1);
                    end
                end
                nv_pkg::S_TIMER: begin
                    if (tmr == 32'd0) begin
                        st <= nv_pkg::S_IDLE;
                        o_charge_pump <= 1'b0;
                    end else begin
                        tmr <= tmr - 32'd1;
                    end
                end
                default: st <= nv_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (st == nv_pkg::S_IDLE && start_wr && ctrl.space && !ctrl.free && addr_lo[1:0] != 2'h3) begin
            blk[addr_lo[1:0]] <= {data_hi, data_lo};
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            done_flag <= 1'b0;
        end else if (ctrl.wr && st == nv_pkg::S_TIMER && tmr == 32'd0 && !core_rst) begin
            done_flag <= 1'b1;
        end else if (i_wr && i_addr == nv_pkg::ADDR_FLAGS2) begin
            done_flag <= i_wdata[nv_pkg::FLAG_DONE_BIT];
        end
    end

    // read port; unmapped and unlock addresses answer zero
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                nv_pkg::ADDR_CTRL: o_rdata <= {ctrl.space, 2'b00, ctrl[4:0]};
                nv_pkg::ADDR_DATA_LO: o_rdata <= data_lo;
                nv_pkg::ADDR_DATA_HI: o_rdata <= {2'b00, data_hi};
                nv_pkg::ADDR_ADDR_LO: o_rdata <= addr_lo;
                nv_pkg::ADDR_ADDR_HI: o_rdata <= {3'b000, addr_hi};
                nv_pkg::ADDR_FLAGS2: o_rdata <= 8'(done_flag) << nv_pkg::FLAG_DONE_BIT;
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_write_done_flag <= 1'b0;
            o_write_abort_flag <= 1'b0;
            o_ext_prog_block <= 1'b0;
        end else begin
            o_write_done_flag <= done_flag;
            o_write_abort_flag <= ctrl.abort;
            o_ext_prog_block <= i_code_protect;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    AST_SPACE_CLEARED: assert property (core_rst |=> !ctrl.space && !ctrl.permit)
        else $error("space or permit survived core reset");
    AST_WR_NEEDS_PERMIT: assert property ($rose(ctrl.wr) |-> $past(ctrl.permit))
        else $error("write started without permit");
    AST_WR_NEEDS_UNLOCK: assert property ($rose(ctrl.wr) |-> $past(armed))
        else $error("write started without unlock");
    AST_RD_ONE_CYCLE: assert property ($rose(ctrl.rd) |=> !ctrl.rd)
        else $error("read bit held too long");
    AST_EE_READ_NEXT: assert property (start_rd && !i_wdata[7] |-> ##2 data_lo == $past(ee_rdata))
        else $error("eeprom read data not loaded");
    AST_DONE_SET: assert property ($fell(ctrl.wr) && !$past(core_rst) |-> done_flag)
        else $error("done flag not set on completion");
    AST_ABORT_SET: assert property (core_rst && ctrl.wr |=> ctrl.abort && !ctrl.wr)
        else $error("abort flag missing");
    AST_PUMP_BUSY: assert property (o_charge_pump |-> ctrl.wr)
        else $error("pump on without write");
    AST_EE_UNIMPL: assert property (start_wr && !ctrl.space && ee_unimpl |=> !o_charge_pump [*2])
        else $error("pump on for unimplemented address");
    AST_UNLOCK_ZERO: assert property (i_rd && i_addr == nv_pkg::ADDR_UNLOCK |=> o_rdata == 8'h00)
        else $error("unlock port read nonzero");
    AST_NO_RESTART: assert property (ctrl.wr && !$fell(ctrl.wr) |-> !$rose(ctrl.rd))
        else $error("read started during write");

    COV_EE_WRITE: cover property (start_wr && !ctrl.space ##1 o_charge_pump);
    COV_ROW_ERASE: cover property (start_wr && ctrl.space && ctrl.free);
    COV_ABORT: cover property (core_rst && ctrl.wr);
endmodule

// ==== tb/nv_reset_src.sv ====
// partner model: the core reset sources that can cut a write short
// assumes the bench calls kick from its one sequential thread
`timescale 1ns/1ps
module nv_reset_src (
    input wire logic i_clk,
    output logic o_ext_reset_pin_n,
    output logic o_wdt_timeout
);
    initial begin
        o_ext_reset_pin_n = 1'b1;
        o_wdt_timeout = 1'b0;
    end
    // reset event source
    // pin is held for n edges so the three-flop synchroniser surely sees it
    task automatic kick(input logic use_pin, input int n);
        @(posedge i_clk);
        if (use_pin) begin
            o_ext_reset_pin_n <= 1'b0;
        end else begin
            o_wdt_timeout <= 1'b1;
        end
        repeat (n) @(posedge i_clk);
        o_ext_reset_pin_n <= 1'b1;
        o_wdt_timeout <= 1'b0;
    endtask
endmodule

// ==== tb/nv_access_ctrl_tb.sv ====
// self-checking bench of the nonvolatile access controller
// assumes nv_pkg compiled first; write time shortened to WC cycles
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module nv_access_ctrl_tb;
    localparam int WC = 40;
    logic i_clk, i_nrst, i_wr, i_rd, i_flash_wp, i_code_protect;
    logic [8:0] i_addr;
    logic [7:0] i_wdata, o_rdata, d;
    logic o_charge_pump, o_write_done_flag, o_write_abort_flag, o_ext_prog_block;
    logic pin_n, wdt, seen, bad;
    int miscompares = 0;
    int n_tests = 0;

    nv_access_ctrl #(.EE_DEPTH(256), .WRITE_CYCLES(WC)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_reset_pin_n(pin_n), .i_wdt_timeout(wdt),
        .i_flash_wp(i_flash_wp), .i_code_protect(i_code_protect), .o_rdata(o_rdata),
        .o_charge_pump(o_charge_pump), .o_write_done_flag(o_write_done_flag),
        .o_write_abort_flag(o_write_abort_flag), .o_ext_prog_block(o_ext_prog_block));
    nv_reset_src rsrc (.i_clk(i_clk), .o_ext_reset_pin_n(pin_n), .o_wdt_timeout(wdt));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task finish_test;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rd(input logic [8:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task commit(input logic [7:0] ctl);
        int k;
        wr(nv_pkg::ADDR_UNLOCK, nv_pkg::UNLOCK_FIRST);
        wr(nv_pkg::ADDR_UNLOCK, nv_pkg::UNLOCK_SECOND);
        wr(nv_pkg::ADDR_CTRL, ctl);
        seen = 1'b0;
        for (k = 0; k < WC + 100 && o_write_done_flag !== 1'b1; k++) begin
            @(posedge i_clk);
            #1 if (o_charge_pump === 1'b1) seen = 1'b1;
        end
        `CHK(o_write_done_flag, 1'b1)
        rd(nv_pkg::ADDR_FLAGS2);
        `CHK(d[nv_pkg::FLAG_DONE_BIT], 1'b1)
        wr(nv_pkg::ADDR_FLAGS2, 8'h00);
    endtask

    task chk_word(input logic [7:0] hi, input logic [7:0] lo);
        wr(nv_pkg::ADDR_CTRL, 8'h85);
        rd(nv_pkg::ADDR_DATA_LO);
        `CHK(d, lo)
        rd(nv_pkg::ADDR_DATA_HI);
        `CHK(d, hi)
    endtask

    task t_reset;
        #1 `CHK({o_charge_pump, o_write_done_flag, o_write_abort_flag}, 3'h0)
        rd(nv_pkg::ADDR_CTRL);
        `CHK(d, 8'h00)
        rd(9'h1ff);
        `CHK(d, 8'h00)
        $display("test reset done");
    endtask

    task t_eeprom;
        i_code_protect <= 1'b1;
        wr(nv_pkg::ADDR_ADDR_HI, 8'h1f);
        wr(nv_pkg::ADDR_ADDR_LO, 8'h5a);
        wr(nv_pkg::ADDR_DATA_LO, 8'hc3);
        wr(nv_pkg::ADDR_CTRL, 8'h04);
        commit(8'h06);
        `CHK(seen, 1'b1)
        `CHK(o_ext_prog_block, 1'b1)
        rd(nv_pkg::ADDR_FLAGS2);
        `CHK(d[nv_pkg::FLAG_DONE_BIT], 1'b0)
        wr(nv_pkg::ADDR_DATA_LO, 8'h00);
        wr(nv_pkg::ADDR_CTRL, 8'h05);
        rd(nv_pkg::ADDR_DATA_LO);
        `CHK(d, 8'hc3)
        rd(nv_pkg::ADDR_CTRL);
        `CHK(d, 8'h04)
        rd(nv_pkg::ADDR_UNLOCK);
        `CHK(d, 8'h00)
        i_code_protect <= 1'b0;
        $display("test eeprom done");
    endtask

    task t_refuse;
        int k;
        wr(nv_pkg::ADDR_CTRL, 8'h00);
        wr(nv_pkg::ADDR_UNLOCK, 8'h55);
        wr(nv_pkg::ADDR_UNLOCK, 8'haa);
        wr(nv_pkg::ADDR_CTRL, 8'h02);
        rd(nv_pkg::ADDR_CTRL);
        `CHK(d, 8'h00)
        wr(nv_pkg::ADDR_CTRL, 8'h04);
        wr(nv_pkg::ADDR_UNLOCK, 8'h55);
        wr(nv_pkg::ADDR_ADDR_LO, 8'h5a);
        wr(nv_pkg::ADDR_UNLOCK, 8'haa);
        wr(nv_pkg::ADDR_CTRL, 8'h06);
        rd(nv_pkg::ADDR_CTRL);
        `CHK(d, 8'h04)
        bad = 1'b0;
        for (k = 0; k < WC + 10; k++) begin
            @(posedge i_clk);
            #1 if (o_charge_pump !== 1'b0 || o_write_done_flag !== 1'b0) bad = 1'b1;
        end
        `CHK(bad, 1'b0)
        $display("test refuse done");
    endtask

    task t_abort;
        int k;
        for (k = 0; k < 2; k++) begin
            wr(nv_pkg::ADDR_CTRL, 8'h04);
            wr(nv_pkg::ADDR_UNLOCK, 8'h55);
            wr(nv_pkg::ADDR_UNLOCK, 8'haa);
            wr(nv_pkg::ADDR_CTRL, 8'h06);
            wr(nv_pkg::ADDR_CTRL, 8'h00);
            rd(nv_pkg::ADDR_CTRL);
            `CHK(d, 8'h02)
            rsrc.kick(k[0], 3);
            repeat (8) @(posedge i_clk);
            #1 `CHK(o_write_abort_flag, 1'b1)
            `CHK(o_charge_pump, 1'b0)
            rd(nv_pkg::ADDR_CTRL);
            `CHK(d, 8'h08)
            rd(nv_pkg::ADDR_ADDR_LO);
            `CHK(d, 8'h5a)
            wr(nv_pkg::ADDR_CTRL, 8'h00);
        end
        $display("test abort done");
    endtask

    // software side: block in order, erase by row
    task t_flash;
        int k;
        wr(nv_pkg::ADDR_ADDR_HI, 8'h00);
        wr(nv_pkg::ADDR_CTRL, 8'h84);
        for (k = 0; k < 4; k++) begin
            wr(nv_pkg::ADDR_ADDR_LO, 8'h10 + 8'(k));
            wr(nv_pkg::ADDR_DATA_HI, 8'h12 + 8'(k));
            wr(nv_pkg::ADDR_DATA_LO, 8'h34);
            commit(8'h86);
            `CHK(seen, k == 3)
        end
        wr(nv_pkg::ADDR_ADDR_HI, 8'h10);
        wr(nv_pkg::ADDR_ADDR_LO, 8'h12);
        chk_word(8'h14, 8'h34);
        wr(nv_pkg::ADDR_CTRL, 8'h94);
        i_flash_wp <= 1'b1;
        commit(8'h96);
        `CHK(seen, 1'b0)
        chk_word(8'h14, 8'h34);
        wr(nv_pkg::ADDR_CTRL, 8'h94);
        i_flash_wp <= 1'b0;
        commit(8'h96);
        `CHK(seen, 1'b1)
        chk_word(8'h3f, 8'hff);
        $display("test flash done");
    endtask

    initial begin
        #200000;
        miscompares++;
        finish_test;
    end

    initial begin
        i_nrst = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 9'h000;
        i_wdata = 8'h00;
        i_flash_wp = 1'b0;
        i_code_protect = 1'b0;
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_reset;
        t_eeprom;
        t_refuse;
        t_abort;
        t_flash;
        finish_test;
    end
endmodule
